// ---- rtl/hvsbs_seq.sv ----
// startup current sequencer, over-voltage latch and brownout filter
module hvsbs_seq
  import hvsbs_pkg::*;
#(
  parameter int unsigned SHORT_FILT_CYC = hvsbs_pkg::HVSBS_SHORT_FILT_CYC,
  parameter int unsigned LONG_BO_CYC = hvsbs_pkg::HVSBS_LONG_BO_CYC,
  parameter int unsigned BROWN_IN_CYC = hvsbs_pkg::HVSBS_BROWN_IN_CYC,
  parameter int unsigned START_DLY_CYC = hvsbs_pkg::HVSBS_START_DLY_CYC,
  parameter int unsigned OFF_DLY_CYC = hvsbs_pkg::HVSBS_OFF_DLY_CYC,
  parameter int unsigned OVP_DLY_CYC = hvsbs_pkg::HVSBS_OVP_DLY_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_line_above_discharge,
  input wire logic i_line_above_min,
  input wire logic i_line_brown_in,
  input wire logic i_line_below_stop,
  input wire logic i_supply_above_inhibit,
  input wire logic i_supply_above_on,
  input wire logic i_supply_below_off,
  input wire logic i_supply_below_reset,
  input wire logic i_supply_overvoltage,
  input wire logic i_fault_input,
  output logic o_low_charge_current,
  output logic o_high_charge_current,
  output logic o_soft_start_go,
  output logic o_drive_enable,
  output logic o_brownout,
  output logic o_ovp_latched,
  output hvsbs_pkg::hvsbs_state_t o_state
);
  import hvsbs_pkg::*;

  // synchroniser bus, one bit per comparator plus one for the fault input
  localparam int unsigned NIN = 10;
  localparam logic [HVSBS_TMR_W-1:0] TMR_ONE = 24'h00_0001;

  // filtered comparator levels
  logic [NIN-1:0] sync_lvl;
  logic line_dis;
  logic line_min;
  logic line_bi;
  logic line_stop;
  logic sup_inh;
  logic sup_on;
  logic sup_off;
  logic sup_rst;
  logic sup_ovp;
  logic fault_input;

  hvsbs_sync #(
    .W(NIN)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_line_above_discharge, i_line_above_min, i_line_brown_in,
              i_line_below_stop, i_supply_above_inhibit, i_supply_above_on,
              i_supply_below_off, i_supply_below_reset, i_supply_overvoltage,
              i_fault_input}),
    .o_level(sync_lvl)
  );

  assign {line_dis, line_min, line_bi, line_stop, sup_inh, sup_on, sup_off,
          sup_rst, sup_ovp, fault_input} = sync_lvl;

  // saturating down-counter helper: loads, decrements, holds at zero
  function automatic logic [HVSBS_TMR_W-1:0] tmr_step(input logic ld,
                                                      input logic [HVSBS_TMR_W-1:0] val,
                                                      input logic [HVSBS_TMR_W-1:0] cur);
    if (ld) begin
      return val;
    end else if (cur != '0) begin
      return cur - TMR_ONE;
    end
    return cur;
  endfunction

  // last count of a running timer; a frozen timer never ends
  function automatic logic tmr_hit(input logic run,
                                   input logic en,
                                   input logic [HVSBS_TMR_W-1:0] cur);
    return run && en && (cur == TMR_ONE);
  endfunction

  // sequencer state and timers
  hvsbs_state_t state_r;
  hvsbs_state_t state_nxt;
  logic lo_r;
  logic hi_r;
  logic lo_nxt;
  logic hi_nxt;
  logic first_on_r;
  logic ovp_r;
  logic [HVSBS_TMR_W-1:0] ovp_tmr_r;
  logic [HVSBS_TMR_W-1:0] dly_tmr_r;
  logic dly_ld;
  logic dly_run_r;
  logic [HVSBS_TMR_W-1:0] dly_val;
  logic [HVSBS_TMR_W-1:0] bi_tmr_r;
  logic bi_ok_r;
  logic [HVSBS_TMR_W-1:0] sf_tmr_r;
  logic sf_run_r;
  logic [HVSBS_TMR_W-1:0] lb_tmr_r;
  logic lb_run_r;
  logic bo_r;
  logic assess;
  logic ss_go_r;
  logic drv_r;
  logic sf_done;
  logic lb_done;
  logic dly_done;
  logic bo_set;
  logic ovp_set;

  assign assess = !lo_r && !hi_r;
  assign dly_done = tmr_hit(dly_run_r, 1'b1, dly_tmr_r);
  assign sf_done = tmr_hit(sf_run_r, assess, sf_tmr_r);
  assign lb_done = tmr_hit(lb_run_r, assess, lb_tmr_r);
  assign bo_set = lb_done && !bi_ok_r;
  assign ovp_set = sup_ovp && (ovp_tmr_r == OVP_DLY_CYC[HVSBS_TMR_W-1:0] - TMR_ONE);

  // over-voltage persistence timer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ovp_tmr_r <= '0;
    end else if (!sup_ovp) begin
      ovp_tmr_r <= '0;
    end else if (ovp_tmr_r != OVP_DLY_CYC[HVSBS_TMR_W-1:0]) begin
      ovp_tmr_r <= ovp_tmr_r + TMR_ONE;
    end
  end

  // over-voltage latch, set wins over clear
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ovp_r <= 1'b0;
    end else if (ovp_set) begin
      ovp_r <= 1'b1;
    end else if (sup_rst) begin
      ovp_r <= 1'b0;
    end
  end

  // brown-in filter count, only while sources are off
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bi_tmr_r <= '0;
    end else if (!assess || !line_bi) begin
      bi_tmr_r <= '0;
    end else if (bi_tmr_r != BROWN_IN_CYC[HVSBS_TMR_W-1:0]) begin
      bi_tmr_r <= bi_tmr_r + TMR_ONE;
    end
  end

  // filter passed, holds while the line stays up and both sources stay off
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bi_ok_r <= 1'b0;
    end else if (!assess || !line_bi) begin
      bi_ok_r <= 1'b0;
    end else if (bi_tmr_r == BROWN_IN_CYC[HVSBS_TMR_W-1:0] - TMR_ONE) begin
      bi_ok_r <= 1'b1;
    end
  end

  // short filter, frozen while a source charges the supply
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sf_tmr_r <= '0;
      sf_run_r <= 1'b0;
    end else if (assess && line_stop && !sf_run_r && !lb_run_r && !bo_r) begin
      sf_tmr_r <= SHORT_FILT_CYC[HVSBS_TMR_W-1:0];
      sf_run_r <= 1'b1;
    end else if (sf_run_r && assess) begin
      sf_tmr_r <= tmr_step(1'b0, '0, sf_tmr_r);
      if (sf_done) begin
        sf_run_r <= 1'b0;
      end
    end
  end

  // long brownout timer, frozen while a source charges the supply
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lb_tmr_r <= '0;
      lb_run_r <= 1'b0;
    end else if (sf_done && !line_bi) begin
      lb_tmr_r <= LONG_BO_CYC[HVSBS_TMR_W-1:0];
      lb_run_r <= 1'b1;
    end else if (lb_run_r && bi_ok_r) begin
      lb_run_r <= 1'b0;
      lb_tmr_r <= '0;
    end else if (lb_run_r && assess) begin
      lb_tmr_r <= tmr_step(1'b0, '0, lb_tmr_r);
      if (lb_done) begin
        lb_run_r <= 1'b0;
      end
    end
  end

  // brownout flag, a passed brown-in filter clears it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bo_r <= 1'b0;
    end else if (bo_set) begin
      bo_r <= 1'b1;
    end else if (bi_ok_r) begin
      bo_r <= 1'b0;
    end
  end

  // shared delay timer for start delay and turn-off delay
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dly_tmr_r <= '0;
      dly_run_r <= 1'b0;
    end else if (dly_ld) begin
      dly_tmr_r <= dly_val;
      dly_run_r <= 1'b1;
    end else if (dly_run_r) begin
      dly_tmr_r <= tmr_step(1'b0, '0, dly_tmr_r);
      if (dly_done) begin
        dly_run_r <= 1'b0;
      end
    end
  end

  // next state and source enables, the latch overrides all
  always_comb begin
    state_nxt = state_r;
    lo_nxt = 1'b0;
    hi_nxt = 1'b0;
    dly_ld = 1'b0;
    dly_val = START_DLY_CYC[HVSBS_TMR_W-1:0];
    case (state_r)
      HVSBS_ST_IDLE: begin
        if (line_dis) begin
          state_nxt = HVSBS_ST_CHARGE;
        end
      end
      HVSBS_ST_CHARGE: begin
        if (sup_on) begin
          state_nxt = HVSBS_ST_WAIT;
          if (!first_on_r) begin
            state_nxt = HVSBS_ST_SETTLE;
            dly_ld = 1'b1;
          end
        end else if (!sup_inh) begin
          lo_nxt = line_dis;
        end else begin
          hi_nxt = line_min;
        end
      end
      HVSBS_ST_SETTLE: begin
        if (dly_done) begin
          state_nxt = HVSBS_ST_WAIT;
        end
      end
      HVSBS_ST_WAIT: begin
        if (bi_ok_r && !fault_input && sup_on) begin
          state_nxt = HVSBS_ST_RUN;
        end else if (sup_off && !dly_run_r) begin
          dly_ld = 1'b1;
          dly_val = OFF_DLY_CYC[HVSBS_TMR_W-1:0];
        end else if (dly_done) begin
          state_nxt = HVSBS_ST_CHARGE;
        end
      end
      HVSBS_ST_RUN: begin
        if (bo_r || fault_input) begin
          state_nxt = HVSBS_ST_WAIT;
        end
      end
      HVSBS_ST_OVP: begin
        if (!ovp_r) begin
          state_nxt = HVSBS_ST_IDLE;
        end
      end
      default: begin
        state_nxt = HVSBS_ST_IDLE;
      end
    endcase
    if (ovp_r) begin
      state_nxt = HVSBS_ST_OVP;
      lo_nxt = 1'b0;
      hi_nxt = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= HVSBS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // source enables follow the state decision
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lo_r <= 1'b0;
      hi_r <= 1'b0;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
    end
  end

  // first turn-on seen, later recharges skip the settle delay
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      first_on_r <= 1'b0;
    end else if (state_r == HVSBS_ST_SETTLE) begin
      first_on_r <= 1'b1;
    end
  end

  // one-cycle soft-start pulse on entry to run
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ss_go_r <= 1'b0;
    end else begin
      ss_go_r <= (state_nxt == HVSBS_ST_RUN) && (state_r != HVSBS_ST_RUN);
    end
  end

  // drive drops on the edge that sets brownout or the latch
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      drv_r <= 1'b0;
    end else begin
      drv_r <= (state_nxt == HVSBS_ST_RUN) && !bo_r && !bo_set && !ovp_set;
    end
  end

  assign o_low_charge_current = lo_r;
  assign o_high_charge_current = hi_r;
  assign o_soft_start_go = ss_go_r;
  assign o_drive_enable = drv_r;
  assign o_brownout = bo_r;
  assign o_ovp_latched = ovp_r;
  assign o_state = state_r;
endmodule

// ---- pkg/hvsbs_pkg.sv ----
// constants and types for the high-voltage startup and brownout sequencer
// Functional notes
// - line above discharge, supply below inhibit: low current
// - supply above inhibit switches to high current
// - high current only below turn-on, line above minimum
// - supply below inhibit returns to low current
// - at turn-on both sources off, await brown-in
// - no brown-in: off until turn-off delay expires
// - after turn-off, recharge supply to turn-on
// - faults or no brown-in: hysteretic charging continues
// - soft start after turn-on, brown-in, recharge
// - over-voltage held for delay latches low power
// - start delay after first turn-on, then timers (the filters and brownout timers here also run during the delay)
// - brownout assessment only while both sources off
// - start needs brown-in filter and turn-on recharge
// - line below stop starts short filter, then long
// - long timer expiry declares brownout, stops drive
// - brown-in held for filter resets long timer
package hvsbs_pkg;
  localparam int unsigned HVSBS_CLK_HZ = 125_000_000;
  localparam int unsigned HVSBS_SHORT_FILT_US = 300;
  localparam int unsigned HVSBS_LONG_BO_MS = 50;
  localparam int unsigned HVSBS_SHORT_FILT_CYC = HVSBS_SHORT_FILT_US * (HVSBS_CLK_HZ / 1_000_000);
  localparam int unsigned HVSBS_LONG_BO_CYC = HVSBS_LONG_BO_MS * (HVSBS_CLK_HZ / 1_000);
  localparam int unsigned HVSBS_BROWN_IN_CYC = 4096;
  localparam int unsigned HVSBS_START_DLY_CYC = 4096;
  localparam int unsigned HVSBS_OFF_DLY_CYC = 4096;
  localparam int unsigned HVSBS_OVP_DLY_CYC = 4096;
  localparam int unsigned HVSBS_TMR_W = 24;

  typedef enum logic [5:0] {
    HVSBS_ST_IDLE = 6'b00_0001,
    HVSBS_ST_CHARGE = 6'b00_0010,
    HVSBS_ST_SETTLE = 6'b00_0100,
    HVSBS_ST_WAIT = 6'b00_1000,
    HVSBS_ST_RUN = 6'b01_0000,
    HVSBS_ST_OVP = 6'b10_0000
  } hvsbs_state_t;
endpackage

// ---- rtl/hvsbs_sync.sv ----
// three-stage synchroniser with agreement filter for comparator inputs
module hvsbs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level changes only once stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_level[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ---- dv/hvsbs_seq_asserts.sv ----
// bound checker for the startup and brownout sequencer
module hvsbs_seq_asserts
  import hvsbs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_supply_below_reset,
  input wire logic o_low_charge_current,
  input wire logic o_high_charge_current,
  input wire logic o_soft_start_go,
  input wire logic o_drive_enable,
  input wire logic o_brownout,
  input wire logic o_ovp_latched,
  input wire hvsbs_pkg::hvsbs_state_t o_state
);
  timeunit 1ns;
  timeprecision 100ps;
  wire lo = o_low_charge_current;
  wire hi = o_high_charge_current;
  wire dark = !lo && !hi;
  wire run = o_state == HVSBS_ST_RUN;
  wire chg = o_state == HVSBS_ST_CHARGE;
  wire held = o_state inside {HVSBS_ST_SETTLE, HVSBS_ST_WAIT, HVSBS_ST_RUN};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  property p_one_src;
    !(lo && hi);
  endproperty
  a_one_src: assert property (p_one_src) else $error("two sources on");
  property p_quiet;
    held && $past(held) |-> dark;
  endproperty
  a_quiet: assert property (p_quiet) else $error("source on past turn-on");
  property p_src;
    !dark |-> chg || $past(chg);
  endproperty
  a_src: assert property (p_src) else $error("source on outside charge");
  property p_ss_pulse;
    o_soft_start_go |=> !o_soft_start_go;
  endproperty
  a_ss_pulse: assert property (p_ss_pulse) else $error("start pulse too long");
  property p_ss_off;
    o_soft_start_go |-> dark ##[0:1] run;
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("start without run");
  property p_drive;
    o_drive_enable |-> !o_brownout && !o_ovp_latched;
  endproperty
  a_drive: assert property (p_drive) else $error("drive during fault");
  property p_bo_quiet;
    $rose(o_brownout) |-> dark && !$past(lo) && !$past(hi);
  endproperty
  a_bo_quiet: assert property (p_bo_quiet) else $error("brownout while charging");
  property p_ovp_hold;
    !i_supply_below_reset [*8] ##0 o_ovp_latched |=> o_ovp_latched;
  endproperty
  a_ovp_hold: assert property (p_ovp_hold) else $error("latch dropped early");
endmodule

bind hvsbs_seq hvsbs_seq_asserts i_chk (.i_mclk, .i_reset, .i_supply_below_reset,
  .o_low_charge_current, .o_high_charge_current, .o_soft_start_go, .o_drive_enable,
  .o_brownout, .o_ovp_latched, .o_state);

// ---- dv/hvsbs_analog.sv ----
// behavioural supply rail and its comparators, fed by the charge sources
module hvsbs_analog (
  input wire logic i_mclk,
  input wire logic i_low_src,
  input wire logic i_high_src,
  input wire logic i_aux_hold,
  input wire logic i_ovp_kick,
  output logic o_above_inhibit,
  output logic o_above_on,
  output logic o_below_off,
  output logic o_below_reset,
  output logic o_overvoltage
);
  timeunit 1ns;
  timeprecision 100ps;
  int vcc = 0;
  // rail sags on bias load unless the aux winding holds it
  always @(posedge i_mclk) begin
    if (i_ovp_kick) vcc <= 320;
    else if (i_high_src) vcc <= vcc + 4;
    else if (i_low_src) vcc <= vcc + 1;
    else if (!i_aux_hold && vcc > 0) vcc <= vcc - 1;
  end
  assign o_above_inhibit = vcc > 10;
  assign o_above_on = vcc >= 200;
  assign o_below_off = vcc < 100;
  assign o_below_reset = vcc < 5;
  assign o_overvoltage = vcc > 300;
endmodule

// ---- dv/hvsbs_seq_tb.sv ----
// self-checking bench for the startup and brownout sequencer
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module hvsbs_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hvsbs_pkg::*;
  localparam int unsigned SHORT = 20, LONG = 50, DLY = 8;
  logic i_mclk = 0, i_reset = 1, i_fault_input = 0, kick = 0;
  logic [1:0] lvl = 2'h3;
  logic [15:0] lfsr = 16'h003c;
  logic inh, von, boff, brst, ovp, low, high, drv, o_soft_start_go, o_brownout, o_ovp_latched;
  hvsbs_state_t o_state;
  int errors = 0, checks = 0, n;
  hvsbs_seq #(.SHORT_FILT_CYC(SHORT), .LONG_BO_CYC(LONG), .BROWN_IN_CYC(DLY),
    .START_DLY_CYC(DLY), .OFF_DLY_CYC(DLY), .OVP_DLY_CYC(DLY)) i_dut (.i_mclk, .i_reset,
    .i_line_above_discharge(lvl != 2'h0), .i_line_above_min(lvl != 2'h0),
    .i_line_brown_in(lvl[1]), .i_line_below_stop(lvl == 2'h0), .i_supply_above_inhibit(inh),
    .i_supply_above_on(von), .i_supply_below_off(boff), .i_supply_below_reset(brst),
    .i_supply_overvoltage(ovp), .i_fault_input, .o_low_charge_current(low),
    .o_high_charge_current(high), .o_soft_start_go, .o_drive_enable(drv), .o_brownout,
    .o_ovp_latched, .o_state);
  hvsbs_analog i_vcc (.i_mclk, .i_low_src(low), .i_high_src(high), .i_aux_hold(drv),
    .i_ovp_kick(kick), .o_above_inhibit(inh), .o_above_on(von), .o_below_off(boff),
    .o_below_reset(brst), .o_overvoltage(ovp));
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  function int bo_min();
    return SHORT + LONG;
  endfunction
  function logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic step(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wt(ref logic s, input logic v);
    for (n = 0; s !== v && n < 3000; n++) step(1);
    if (n >= 3000) begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, s, v);
      test_done();
    end
  endtask
  initial begin
    step(10);
    `CHK(o_state, HVSBS_ST_IDLE)
    i_reset = 0;
    wt(low, 1'b1);
    `CHK(high, 1'b0)
    wt(high, 1'b1);
    `CHK(low, 1'b0)
    wt(o_soft_start_go, 1'b1);
    `CHK({low, high, von}, 3'b001)
    step(1);
    `CHK(o_soft_start_go, 1'b0)
    wt(drv, 1'b1);
    // random dips shorter than the short filter ride through
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      lvl = 2'h0;
      step(1 + lfsr[3:0] % 10);
      lvl = 2'h3;
      step(40);
      `CHK({o_brownout, drv}, 2'b01)
    end
    lvl = 2'h0;
    wt(o_brownout, 1'b1);
    `CHK(n >= bo_min(), 1'b1)
    `CHK(drv, 1'b0)
    lvl = 2'h1;
    wt(high, 1'b1);
    `CHK(boff, 1'b1)
    wt(high, 1'b0);
    `CHK(von, 1'b1)
    lvl = 2'h3;
    wt(drv, 1'b1);
    `CHK(o_brownout, 1'b0)
    i_fault_input = 1;
    wt(drv, 1'b0);
    `CHK(n <= 12, 1'b1)
    wt(high, 1'b1);
    wt(high, 1'b0);
    `CHK({drv, von}, 2'b01)
    i_fault_input = 0;
    wt(drv, 1'b1);
    kick = 1;
    step(30);
    kick = 0;
    `CHK({o_ovp_latched, low, high, drv}, 4'h8)
    wt(o_ovp_latched, 1'b0);
    `CHK(brst, 1'b1)
    wt(low, 1'b1);
    i_reset = 1;
    step(2);
    `CHK({low, high, o_soft_start_go, drv, o_brownout, o_ovp_latched}, 6'h00)
    `CHK(o_state, HVSBS_ST_IDLE)
    i_reset = 0;
    wt(o_soft_start_go, 1'b1);
    `CHK(von, 1'b1)
    test_done();
  end
endmodule
